// [core/prot_monitor.sv]
// input conditioning, power-good deglitch and on-chip thermal monitor
// Functional notes
// - thermal shutdown sets at the selected 130/135/140/145 C threshold and clears 10 C below it.
// - thermal warning sets at 125 C and clears once temperature is down to 115 C.
// - enable, overvoltage and feedback inputs pass a fixed 10 us filter before any other use.
// - the FET start follows a rising filtered enable only after the selected 0 to 512 ms deglitch.
// - power-good assertion is delayed by a programmable 0 to 15 ms in 1 ms steps.
// - power-good deassertion is delayed by its own programmable 0 to 15 ms in 1 ms steps.
// - the temperature used for both comparisons is refreshed every 200 ms.
`timescale 1ns/1ps
`default_nettype none
module prot_monitor
	import prot_pkg::*;
#(
	parameter cnt_t MS_CYCLES = MS_CYCLES_DEF,
	parameter cnt_t TEMP_REFRESH_CYCLES = TEMP_REFRESH_DEF
)
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic undervoltage_enable_input,
	input wire logic overvoltage_input,
	input wire logic feedback_input,
	input wire logic [1:0] thermal_shutdown_threshold_sel,
	input wire logic [3:0] enable_rise_deglitch_sel,
	input wire logic [3:0] power_good_rise_deglitch_sel,
	input wire logic [3:0] power_good_fall_deglitch_sel,
	input wire logic signed [8:0] temp_in,
	output logic undervoltage_enable_filt,
	output logic overvoltage_filt,
	output logic feedback_filt,
	output logic fet_start,
	output logic power_good_output,
	output logic thermal_shutdown,
	output logic thermal_warning
);

	// ****************************************************************
	// helpers
	// ****************************************************************
	// scale a whole number of ms to clock cycles
	function automatic cnt_t ms_to_cycles(input logic [9:0] ms, input cnt_t ms_cycles);
		ms_to_cycles = cnt_t'(ms) * ms_cycles;
	endfunction

	// codes above the last table entry use the longest time, the safe side
	function automatic logic [9:0] enable_rise_deglitch_sel_ms(input logic [3:0] sel);
		enable_rise_deglitch_sel_ms = (sel > ENABLE_RISE_DEGLITCH_SEL_LAST) ? ENABLE_RISE_DEGLITCH_SEL_MS[ENABLE_RISE_DEGLITCH_SEL_LAST] : ENABLE_RISE_DEGLITCH_SEL_MS[sel];
	endfunction

	function automatic temp_t tsd_threshold(input logic [1:0] sel);
		case (sel)
			2'h0: tsd_threshold = TSD_130_C;
			2'h1: tsd_threshold = TSD_135_C;
			2'h2: tsd_threshold = TSD_140_C;
			default: tsd_threshold = TSD_145_C;
		endcase
	endfunction

	// ****************************************************************
	// fixed input filters
	// ****************************************************************
	dg_if uv_if();
	dg_if ov_if();
	dg_if fb_if();

	// comparator outputs are raw; nothing downstream sees them unfiltered
	assign uv_if.raw = undervoltage_enable_input;
	assign uv_if.limit = FIX_CYCLES;
	assign ov_if.raw = overvoltage_input;
	assign ov_if.limit = FIX_CYCLES;
	assign fb_if.raw = feedback_input;
	assign fb_if.limit = FIX_CYCLES;

	deglitch uv_filter (.core_clk(core_clk), .nrst(nrst), .port(uv_if.filter));
	deglitch ov_filter (.core_clk(core_clk), .nrst(nrst), .port(ov_if.filter));
	deglitch fb_filter (.core_clk(core_clk), .nrst(nrst), .port(fb_if.filter));

	assign undervoltage_enable_filt = uv_if.filt;
	assign overvoltage_filt = ov_if.filt;
	assign feedback_filt = fb_if.filt;

	// ****************************************************************
	// enable rise deglitch before FET start
	// ****************************************************************
	dg_if en_if();
	cnt_t en_rise_cycles_w;

	// only the rising edge waits; a falling enable stops the FET at once
	assign en_rise_cycles_w = ms_to_cycles(enable_rise_deglitch_sel_ms(enable_rise_deglitch_sel), MS_CYCLES);
	assign en_if.raw = uv_if.filt;
	assign en_if.limit = uv_if.filt ? en_rise_cycles_w : '0;

	deglitch en_filter (.core_clk(core_clk), .nrst(nrst), .port(en_if.filter));
	assign fet_start = en_if.filt;

	// ****************************************************************
	// power-good deglitch
	// ****************************************************************
	dg_if pg_if();
	cnt_t pg_rise_cycles_w;
	cnt_t pg_fall_cycles_w;

	// feedback comparator judges the output; each direction has its own delay
	assign pg_rise_cycles_w = ms_to_cycles({6'h00, power_good_rise_deglitch_sel}, MS_CYCLES);
	assign pg_fall_cycles_w = ms_to_cycles({6'h00, power_good_fall_deglitch_sel}, MS_CYCLES);
	assign pg_if.raw = fb_if.filt;
	assign pg_if.limit = fb_if.filt ? pg_rise_cycles_w : pg_fall_cycles_w;

	deglitch pg_filter (.core_clk(core_clk), .nrst(nrst), .port(pg_if.filter));
	assign power_good_output = pg_if.filt;

	// ****************************************************************
	// temperature refresh
	// ****************************************************************
	cnt_t refresh_cnt_r;
	cnt_t refresh_cnt_nxt;
	logic refresh_w;
	temp_t temp_r;
	temp_t temp_nxt;

	// the converter value is taken once per refresh period, not tracked
	assign refresh_w = refresh_cnt_r + 32'h0000_0001 >= TEMP_REFRESH_CYCLES;
	assign refresh_cnt_nxt = refresh_w ? '0 : refresh_cnt_r + 32'h0000_0001;
	assign temp_nxt = refresh_w ? temp_t'(temp_in) : temp_r;

	// refresh timer and held sample
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			refresh_cnt_r <= '0;
			temp_r <= TEMP_RESET_C;
		end
		else
		begin
			refresh_cnt_r <= refresh_cnt_nxt;
			temp_r <= temp_nxt;
		end
	end

	// ****************************************************************
	// thermal shutdown and warning comparators
	// ****************************************************************
	temp_t tsd_thr_w;
	temp_t tsd_rel_w;
	logic tsd_r;
	logic tsd_nxt;
	logic warn_r;
	logic warn_nxt;

	// hysteresis keeps the flags from chattering on a noisy reading
	assign tsd_thr_w = tsd_threshold(thermal_shutdown_threshold_sel);
	assign tsd_rel_w = tsd_thr_w - TSD_HYST_C;
	assign tsd_nxt = (temp_r >= tsd_thr_w) ? 1'b1 : ((temp_r <= tsd_rel_w) ? 1'b0 : tsd_r);
	assign warn_nxt = (temp_r >= WARN_SET_C) ? 1'b1 : ((temp_r <= WARN_CLR_C) ? 1'b0 : warn_r);

	// thermal flags
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			tsd_r <= 1'b0;
			warn_r <= 1'b0;
		end
		else
		begin
			tsd_r <= tsd_nxt;
			warn_r <= warn_nxt;
		end
	end

	assign thermal_shutdown = tsd_r;
	assign thermal_warning = warn_r;

	// ****************************************************************
	// check helpers
	// ****************************************************************
	cnt_t uv_run_r;
	cnt_t uv_run_nxt;
	cnt_t en_run_r;
	cnt_t en_run_nxt;

	// run lengths in front of two filters, saturating so a long hold never wraps back to zero
	assign uv_run_nxt = !undervoltage_enable_input ? '0 :
		((uv_run_r >= FIX_CYCLES) ? uv_run_r : uv_run_r + 32'h0000_0001);
	assign en_run_nxt = !undervoltage_enable_filt ? '0 : ((en_run_r == '1) ? en_run_r : en_run_r + 32'h0000_0001);

	// run counters, watched by the checks only
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			uv_run_r <= '0;
			en_run_r <= '0;
		end
		else
		begin
			uv_run_r <= uv_run_nxt;
			en_run_r <= en_run_nxt;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	chk_tsd_set: assert property (@(posedge core_clk) disable iff (!nrst)
		(temp_r >= tsd_thr_w) |=> thermal_shutdown)
		else $error("shutdown not raised at threshold");
	chk_tsd_hyst_hold: assert property (@(posedge core_clk) disable iff (!nrst)
		(thermal_shutdown && (temp_r > tsd_thr_w - TSD_HYST_C)) |=> thermal_shutdown)
		else $error("shutdown released inside hysteresis");
	chk_tsd_release: assert property (@(posedge core_clk) disable iff (!nrst)
		(temp_r <= tsd_thr_w - TSD_HYST_C) |=> !thermal_shutdown)
		else $error("shutdown not released below hysteresis");
	chk_warn_set: assert property (@(posedge core_clk) disable iff (!nrst)
		(temp_r >= WARN_SET_C) |=> thermal_warning)
		else $error("warning not raised at 125 C");
	chk_warn_clear: assert property (@(posedge core_clk) disable iff (!nrst)
		(thermal_warning && (temp_r > WARN_CLR_C)) |=> thermal_warning)
		else $error("warning cleared above 115 C");
	chk_fixed_filter_len: assert property (@(posedge core_clk) disable iff (!nrst)
		$rose(undervoltage_enable_filt) |-> $past(undervoltage_enable_input, 1) && (uv_run_r >= FIX_CYCLES))
		else $error("enable filter passed a glitch");
	chk_fet_rise_delay: assert property (@(posedge core_clk) disable iff (!nrst)
		$rose(fet_start) |-> (en_run_r >= $past(en_rise_cycles_w)))
		else $error("wrong enable rise deglitch");
	chk_fet_fall_fast: assert property (@(posedge core_clk) disable iff (!nrst)
		(!undervoltage_enable_filt && fet_start) |=> !fet_start)
		else $error("fet start not dropped with enable");
	chk_pg_rise_delay: assert property (@(posedge core_clk) disable iff (!nrst)
		(feedback_filt && !power_good_output) |-> (pg_if.limit == cnt_t'(power_good_rise_deglitch_sel) * MS_CYCLES))
		else $error("wrong power-good rise deglitch");
	chk_pg_fall_delay: assert property (@(posedge core_clk) disable iff (!nrst)
		(!feedback_filt && power_good_output) |-> (pg_if.limit == cnt_t'(power_good_fall_deglitch_sel) * MS_CYCLES))
		else $error("wrong power-good fall deglitch");
	chk_temp_refresh: assert property (@(posedge core_clk) disable iff (!nrst)
		(refresh_cnt_r != '0) |-> $stable(temp_r) && (refresh_cnt_r < TEMP_REFRESH_CYCLES))
		else $error("temperature changed between refreshes");

endmodule
`default_nettype wire

// [core/prot_pkg.sv]
// shared constants and types for the protection deglitch and thermal monitor
package prot_pkg;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef logic [31:0] cnt_t;
	typedef logic signed [8:0] temp_t;

	// ****************************************************************
	// clock and time base
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 5;
	localparam int FIX_FILTER_NS = 10000;
	// fixed filter is a nominal time, rounded up to whole cycles
	localparam cnt_t FIX_CYCLES = cnt_t'((FIX_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int MS_NS = 1000000;
	localparam cnt_t MS_CYCLES_DEF = cnt_t'(MS_NS / CLK_PERIOD_NS);
	localparam int TEMP_REFRESH_MS = 200;
	localparam cnt_t TEMP_REFRESH_DEF = cnt_t'(TEMP_REFRESH_MS) * MS_CYCLES_DEF;

	// ****************************************************************
	// enable rise deglitch table, in ms
	// ****************************************************************
	localparam logic [3:0] ENABLE_RISE_DEGLITCH_SEL_LAST = 4'hA;
	localparam logic [9:0] ENABLE_RISE_DEGLITCH_SEL_MS [0:10] = '{10'h000, 10'h004, 10'h008, 10'h010, 10'h020, 10'h040,
		10'h080, 10'h100, 10'h12C, 10'h190, 10'h200};

	// ****************************************************************
	// thermal thresholds, degrees C
	// ****************************************************************
	localparam temp_t TSD_130_C = 9'sh082;
	localparam temp_t TSD_135_C = 9'sh087;
	localparam temp_t TSD_140_C = 9'sh08C;
	localparam temp_t TSD_145_C = 9'sh091;
	localparam temp_t TSD_HYST_C = 9'sh00A;
	localparam temp_t WARN_SET_C = 9'sh07D;
	localparam temp_t WARN_CLR_C = 9'sh073;
	localparam temp_t TEMP_RESET_C = 9'sh000;

endpackage

// [core/dg_if.sv]
// signals between the monitor and one deglitch filter
`timescale 1ns/1ps
`default_nettype none
interface dg_if;
	import prot_pkg::*;
	logic raw;
	prot_pkg::cnt_t limit;
	logic filt;
	modport owner (output raw, output limit, input filt);
	modport filter (input raw, input limit, output filt);
endinterface
`default_nettype wire

// [core/deglitch.sv]
// level deglitch filter with a per-cycle hold limit
`timescale 1ns/1ps
`default_nettype none
module deglitch
	import prot_pkg::*;
(
	input wire logic core_clk,
	input wire logic nrst,
	dg_if.filter port
);

	// ****************************************************************
	// hold counter
	// ****************************************************************
	cnt_t cnt_r;
	cnt_t cnt_nxt;
	logic differ_w;
	logic done_w;

	// a new level passes only after limit cycles of continuous hold
	assign differ_w = port.raw != port.filt;
	assign done_w = (port.limit == '0) || (cnt_r + 32'h0000_0001 >= port.limit);
	assign cnt_nxt = (differ_w && !done_w) ? cnt_r + 32'h0000_0001 : '0; // reverting restarts

	// counter and filtered level
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			cnt_r <= '0;
			port.filt <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			if (differ_w && done_w)
				port.filt <= port.raw;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	chk_pass_after_hold: assert property (@(posedge core_clk) disable iff (!nrst)
		$changed(port.filt) |-> (port.filt == $past(port.raw)) &&
		(($past(port.limit) == '0) || ($past(cnt_r) + 32'h0000_0001 >= $past(port.limit))))
		else $error("filter changed before hold time");
	chk_restart_on_revert: assert property (@(posedge core_clk) disable iff (!nrst)
		(port.raw == port.filt) |=> (cnt_r == '0))
		else $error("hold count not restarted");

endmodule
`default_nettype wire

// [tb/analog_front.sv]
// model of the comparators and temperature converter in front of the monitor
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// analog front end model
// ****************************************************************
module analog_front
	import prot_pkg::*;
(
	input wire logic core_clk,
	input wire logic uv_level,
	input wire logic ov_level,
	input wire logic fb_level,
	input wire logic signed [8:0] die_temp,
	output wire logic uv_cmp,
	output wire logic ov_cmp,
	output wire logic fb_cmp,
	output wire logic signed [8:0] temp_code
);
	// comparators follow the sensed level at once, the converter passes the die temperature straight through
	// a real comparator chatters; glitches are commanded explicitly by the bench instead
	assign uv_cmp = uv_level;
	assign ov_cmp = ov_level;
	assign fb_cmp = fb_level;
	assign temp_code = die_temp;
endmodule
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the protection deglitch and thermal monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
	$display("unexpected at %0t: got %0h exp %0h", $time, (a), (b)); end end
// ****************************************************************
// testbench top
// ****************************************************************
module testbench
	import prot_pkg::*;
;
	// a short ms keeps the longest enable code inside the cycle budget
	localparam int MS = 5;
	logic core_clk, nrst, uv_l, ov_l, fb_l, uv_c, ov_c, fb_c;
	logic [1:0] tsd_sel;
	logic [3:0] en_sel, pgr_sel, pgf_sel;
	logic signed [8:0] die_t, t_code;
	logic uv_f, ov_f, fb_f, fet, pg, tsd, warn, sd_m, wr_m;
	int err_count, tests_run, n, i, s, k, thr;
	integer seed;
	int t_list [0:8];
	analog_front afe (.core_clk(core_clk), .uv_level(uv_l), .ov_level(ov_l), .fb_level(fb_l), .die_temp(die_t),
		.uv_cmp(uv_c), .ov_cmp(ov_c), .fb_cmp(fb_c), .temp_code(t_code));
	prot_monitor #(.MS_CYCLES(MS), .TEMP_REFRESH_CYCLES(50)) dut (.core_clk(core_clk), .nrst(nrst),
		.undervoltage_enable_input(uv_c), .overvoltage_input(ov_c), .feedback_input(fb_c),
		.thermal_shutdown_threshold_sel(tsd_sel), .enable_rise_deglitch_sel(en_sel),
		.power_good_rise_deglitch_sel(pgr_sel), .power_good_fall_deglitch_sel(pgf_sel), .temp_in(t_code),
		.undervoltage_enable_filt(uv_f), .overvoltage_filt(ov_f), .feedback_filt(fb_f), .fet_start(fet),
		.power_good_output(pg), .thermal_shutdown(tsd), .thermal_warning(warn));
	// free running 200 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// edges a deglitch of limit l takes; a zero limit still costs one edge
	function automatic int dg_edges(input int l);
		return (l == 0) ? 1 : l;
	endfunction
	function automatic logic pick(input int w);
		case (w)
			0: return uv_f;
			1: return ov_f;
			2: return fb_f;
			3: return fet;
			default: return pg;
		endcase
	endfunction
	task automatic drive(input int w, input logic v);
		@(posedge core_clk);
		if (w == 0) uv_l <= v;
		else if (w == 1) ov_l <= v;
		else fb_l <= v;
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// counts edges until the watched output reaches lvl; bounded so a hang ends the run
	task automatic meas(input int w, input int lim, input logic lvl, output int cnt);
		cnt = 0;
		do
		begin
			@(posedge core_clk);
			#1;
			cnt++;
		end
		while (pick(w) !== lvl && cnt < lim);
		if (pick(w) !== lvl)
		begin
			err_count++;
			$display("unexpected at %0t: got %0h exp %0h", $time, pick(w), lvl);
			complete_run();
		end
	endtask
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial
	begin
		seed = 32'h67845B66;
		err_count = 0;
		tests_run = 0;
		{nrst, uv_l, ov_l, fb_l, tsd_sel, en_sel, pgr_sel, pgf_sel} = '0;
		die_t = 9'sh000;
		repeat (8) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		#1;
		`CHK({uv_f, ov_f, fb_f, fet, pg, tsd, warn}, 7'h00)
		// fixed filter: a one-edge dropout restarts the count, then full hold passes
		for (i = 0; i < 3; i++)
		begin
			drive(i, 1'b1);
			repeat (1000) @(posedge core_clk);
			drive(i, 1'b0);
			drive(i, 1'b1);
			meas(i, 3000, 1'b1, n);
			`CHK(n, 2000)
			drive(i, 1'b0);
			meas(i, 3000, 1'b0, n);
			`CHK(n, 2000)
		end
		// every enable code, plus one above the table that reads as the longest
		for (s = 0; s < 12; s++)
		begin
			@(posedge core_clk);
			en_sel <= 4'(s);
			drive(0, 1'b1);
			meas(0, 3000, 1'b1, n);
			meas(3, 6000, 1'b1, n);
			`CHK(n, dg_edges(int'(ENABLE_RISE_DEGLITCH_SEL_MS[(s > 10) ? 10 : s]) * MS))
			drive(0, 1'b0);
			meas(0, 3000, 1'b0, n);
			meas(3, 5, 1'b0, n);
			`CHK(n, 1)
		end
		// power-good both ways, corner selects first then random ones
		for (i = 0; i < 4; i++)
		begin
			@(posedge core_clk);
			pgr_sel <= (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($random(seed));
			pgf_sel <= (i == 0) ? 4'hF : (i == 1) ? 4'h0 : 4'($random(seed));
			drive(2, 1'b1);
			meas(2, 3000, 1'b1, n);
			meas(4, 300, 1'b1, n);
			`CHK(n, dg_edges(int'(pgr_sel) * MS))
			drive(2, 1'b0);
			meas(2, 3000, 1'b0, n);
			meas(4, 300, 1'b0, n);
			`CHK(n, dg_edges(int'(pgf_sel) * MS))
		end
		// thermal: boundaries of both windows at each threshold, plus a random point
		sd_m = 1'b0;
		wr_m = 1'b0;
		for (s = 0; s < 4; s++)
		begin
			@(posedge core_clk);
			tsd_sel <= 2'(s);
			thr = 130 + 5 * s;
			t_list = '{124, 125, 116, 115, thr - 1, thr, thr - 9, thr - 10, ($random(seed) & 255) - 40};
			for (k = 0; k < 9; k++)
			begin
				@(posedge core_clk);
				die_t <= 9'(t_list[k]);
				repeat (102) @(posedge core_clk);
				#1;
				if (t_list[k] >= thr) sd_m = 1'b1;
				else if (t_list[k] <= thr - 10) sd_m = 1'b0;
				if (t_list[k] >= 125) wr_m = 1'b1;
				else if (t_list[k] <= 115) wr_m = 1'b0;
				`CHK(tsd, sd_m)
				`CHK(warn, wr_m)
			end
		end
		complete_run();
	end
endmodule
`default_nettype wire
